//--- design/dic_defines.svh
// register offsets, field positions and reset values of the display interrupt control
`ifndef DIC_DEFINES_SVH
`define DIC_DEFINES_SVH

// register offsets
`define DIC_ADDR_ENABLE 8'h0b
`define DIC_ADDR_FLAGS 8'h0c
`define DIC_ADDR_MASK 8'h0d
`define DIC_ADDR_PENDING 8'h40
`define DIC_ADDR_CTRL 8'h41
`define DIC_ADDR_SWSET 8'h42
`define DIC_ADDR_OVERRUN 8'h43

// source bit positions, shared by enable, flags, mask, pending and overrun
`define DIC_BIT_WAKEUP 7
`define DIC_BIT_EXT_PIN 6
`define DIC_BIT_I2C 5
`define DIC_BIT_VSYNC 4
`define DIC_BIT_KEYPAD 3
`define DIC_BIT_PROC_DONE 2
`define DIC_BIT_PWM1 1
`define DIC_BIT_PWM0 0

// control register fields
`define DIC_CTRL_EXT_FALL 0
`define DIC_CTRL_SWSET_EN 1

// widths and reset values
`define DIC_NUM_SRC 8
`define DIC_CTRL_W 2
`define DIC_RST_BYTE 8'h00
`define DIC_RST_CTRL 2'h0
`define DIC_ZERO_BYTE 8'h00
`define DIC_ZERO_CTRL_PAD 6'h00

`endif

//--- design/dic_flag_cell.sv
// one sticky interrupt flag with write-1-to-clear and a read-cleared overrun bit
`timescale 1ns/1ps
`include "dic_defines.svh"

module dic_flag_cell (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // event and software actions
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic ovr_clr_i,
  // state
  output logic flag_o,
  output logic ovr_o
);

  logic flag_r;
  logic flag_nxt;
  logic ovr_r;
  logic ovr_nxt;
  wire logic ovr_hit;

  // a second event while the flag still stands is lost to software, so record it
  assign ovr_hit = set_i & flag_r & ~clr_i;
  // set beats clear so an event in the clearing cycle is kept
  assign flag_nxt = set_i | (flag_r & ~clr_i);
  assign ovr_nxt = ovr_hit | (ovr_r & ~ovr_clr_i);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flag_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  assign flag_o = flag_r;
  assign ovr_o = ovr_r;

endmodule

//--- design/dic_pkg.sv
// types shared by the display interrupt control files
package dic_pkg;

  // one register access from the host port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dic_bus_req_t;

  // one-cycle event pulses from the interrupt sources, msb first as in the registers
  typedef struct packed {
    logic wakeup;
    logic ext_pin;
    logic i2c;
    logic vsync;
    logic keypad;
    logic proc_done;
    logic pwm1;
    logic pwm0;
  } dic_src_t;

endpackage

//--- design/dic_top.sv
// display interrupt control: enable, event flags, mask and host interrupt request
//
// Contract
// [RULE1] eight-bit enable register, reset zero, one per source
// [RULE2] enable bit 6 gates external pin interrupt
// [RULE3] enable bit 5 gates I2C master interrupt
// [RULE4] enable bit 4 gates VSYNC time-base interrupt
// [RULE5] enable bit 2 gates shared completion interrupt
// [RULE6] enable bit 1 gates PWM timer 1
// [RULE7] enable bit 0 gates PWM timer 0
// [RULE8] eight-bit event flags, reset zero, read back
// [RULE9] flag 7 wakeup, write one clears
// [RULE10] flag 6 external pin, write one clears
// [RULE11] flag 5 I2C master, write one clears
// [RULE12] flag 4 VSYNC, write one clears
// [RULE13] flag 3 keypad scan, write one clears
// [RULE14] flag 2 shared completion, write one clears
// [RULE15] flags 1 and 0 PWM timers, write-one clear
// [RULE16] masked source never raises the request
// [RULE17] flags sticky; request while set, enabled, unmasked
`timescale 1ns/1ps
`include "dic_defines.svh"

module dic_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // host register port
  input wire dic_pkg::dic_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // interrupt sources, one-cycle pulses
  input wire dic_pkg::dic_src_t src_i,
  // external interrupt input pin level
  input wire logic ext_pin_i,
  // request to the host
  output logic irq_o,
  // per-source pending view for neighbouring logic
  output logic [7:0] pending_o
);

  // address match used by every register decode
  function automatic logic dic_hit(input logic [7:0] addr, input logic [7:0] target);
    dic_hit = (addr == target);
  endfunction

  // registers
  logic [7:0] enable_r;
  logic [7:0] enable_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [`DIC_CTRL_W-1:0] ctrl_r;
  logic [`DIC_CTRL_W-1:0] ctrl_nxt;
  logic ext_pin_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic [7:0] pending_r;

  // decode
  wire logic hit_enable;
  wire logic hit_flags;
  wire logic hit_mask;
  wire logic hit_pending;
  wire logic hit_ctrl;
  wire logic hit_swset;
  wire logic hit_overrun;
  wire logic wr_enable;
  wire logic wr_flags;
  wire logic wr_mask;
  wire logic wr_ctrl;
  wire logic wr_swset;
  wire logic rd_overrun;
  wire logic rd_mapped;

  // event paths
  wire logic ext_rise;
  wire logic ext_fall;
  wire logic ext_event;
  wire logic [7:0] hw_event;
  wire logic [7:0] sw_event;
  wire logic [7:0] set_vec;
  wire logic [7:0] clr_vec;
  wire logic [7:0] flags;
  wire logic [7:0] overrun;
  wire logic [7:0] pending;
  wire logic [7:0] ctrl_view;

  assign hit_enable = dic_hit(bus_i.addr, `DIC_ADDR_ENABLE);
  assign hit_flags = dic_hit(bus_i.addr, `DIC_ADDR_FLAGS);
  assign hit_mask = dic_hit(bus_i.addr, `DIC_ADDR_MASK);
  assign hit_pending = dic_hit(bus_i.addr, `DIC_ADDR_PENDING);
  assign hit_ctrl = dic_hit(bus_i.addr, `DIC_ADDR_CTRL);
  assign hit_swset = dic_hit(bus_i.addr, `DIC_ADDR_SWSET);
  assign hit_overrun = dic_hit(bus_i.addr, `DIC_ADDR_OVERRUN);

  assign wr_enable = bus_i.wr & hit_enable;
  assign wr_flags = bus_i.wr & hit_flags;
  assign wr_mask = bus_i.wr & hit_mask;
  assign wr_ctrl = bus_i.wr & hit_ctrl;
  assign wr_swset = bus_i.wr & hit_swset;
  assign rd_overrun = bus_i.rd & hit_overrun;
  assign rd_mapped = hit_enable | hit_flags | hit_mask | hit_pending
                   | hit_ctrl | hit_swset | hit_overrun;

  // enable register, plain read/write
  assign enable_nxt = wr_enable ? bus_i.wdata : enable_r; // [RULE1]

  // mask register, 1 blocks the request but not the flag
  assign mask_nxt = wr_mask ? bus_i.wdata : mask_r; // [RULE16]

  assign ctrl_nxt = wr_ctrl ? bus_i.wdata[`DIC_CTRL_W-1:0] : ctrl_r;
  assign ctrl_view = {`DIC_ZERO_CTRL_PAD, ctrl_r};

  // external pin: the pin is synchronous, so only the previous level is kept for edges
  assign ext_rise = ext_pin_i & ~ext_pin_r;
  assign ext_fall = ~ext_pin_i & ext_pin_r;
  assign ext_event = ctrl_r[`DIC_CTRL_EXT_FALL] ? ext_fall : ext_rise; // [RULE10]

  // hardware events in register order
  assign hw_event[`DIC_BIT_WAKEUP] = src_i.wakeup; // [RULE9]
  assign hw_event[`DIC_BIT_EXT_PIN] = ext_event | src_i.ext_pin; // [RULE10]
  assign hw_event[`DIC_BIT_I2C] = src_i.i2c; // [RULE11]
  assign hw_event[`DIC_BIT_VSYNC] = src_i.vsync; // [RULE12]
  assign hw_event[`DIC_BIT_KEYPAD] = src_i.keypad; // [RULE13]
  assign hw_event[`DIC_BIT_PROC_DONE] = src_i.proc_done; // [RULE14]
  assign hw_event[`DIC_BIT_PWM1] = src_i.pwm1; // [RULE15]
  assign hw_event[`DIC_BIT_PWM0] = src_i.pwm0; // [RULE15]

  // software set lets bring-up code exercise the request path; off after reset
  assign sw_event = (wr_swset & ctrl_r[`DIC_CTRL_SWSET_EN]) ? bus_i.wdata : `DIC_ZERO_BYTE;

  // flags record events whatever the enable, so a disabled source can still be polled
  assign set_vec = hw_event | sw_event; // [RULE17]
  // write 1 clears, write 0 leaves the flag alone
  assign clr_vec = wr_flags ? bus_i.wdata : `DIC_ZERO_BYTE; // [RULE9] [RULE13]

  genvar gi;
  generate
    for (gi = 0; gi < `DIC_NUM_SRC; gi = gi + 1) begin : g_flag
      dic_flag_cell u_cell (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .set_i(set_vec[gi]),
        .clr_i(clr_vec[gi]), // [RULE10] [RULE11] [RULE12] [RULE14] [RULE15]
        .ovr_clr_i(rd_overrun),
        .flag_o(flags[gi]), // [RULE8]
        .ovr_o(overrun[gi])
      );
    end
  endgenerate

  // each enable bit gates its own source onto the request
  assign pending[`DIC_BIT_WAKEUP] = flags[`DIC_BIT_WAKEUP] & enable_r[`DIC_BIT_WAKEUP]
                                  & ~mask_r[`DIC_BIT_WAKEUP]; // [RULE1]
  assign pending[`DIC_BIT_EXT_PIN] = flags[`DIC_BIT_EXT_PIN] & enable_r[`DIC_BIT_EXT_PIN]
                                   & ~mask_r[`DIC_BIT_EXT_PIN]; // [RULE2]
  assign pending[`DIC_BIT_I2C] = flags[`DIC_BIT_I2C] & enable_r[`DIC_BIT_I2C]
                               & ~mask_r[`DIC_BIT_I2C]; // [RULE3]
  assign pending[`DIC_BIT_VSYNC] = flags[`DIC_BIT_VSYNC] & enable_r[`DIC_BIT_VSYNC]
                                 & ~mask_r[`DIC_BIT_VSYNC]; // [RULE4]
  assign pending[`DIC_BIT_KEYPAD] = flags[`DIC_BIT_KEYPAD] & enable_r[`DIC_BIT_KEYPAD]
                                  & ~mask_r[`DIC_BIT_KEYPAD]; // [RULE1]
  assign pending[`DIC_BIT_PROC_DONE] = flags[`DIC_BIT_PROC_DONE]
                                     & enable_r[`DIC_BIT_PROC_DONE]
                                     & ~mask_r[`DIC_BIT_PROC_DONE]; // [RULE5]
  assign pending[`DIC_BIT_PWM1] = flags[`DIC_BIT_PWM1] & enable_r[`DIC_BIT_PWM1]
                                & ~mask_r[`DIC_BIT_PWM1]; // [RULE6]
  assign pending[`DIC_BIT_PWM0] = flags[`DIC_BIT_PWM0] & enable_r[`DIC_BIT_PWM0]
                                & ~mask_r[`DIC_BIT_PWM0]; // [RULE7]

  // read mux; unmapped addresses read zero, and the data stand only in the cycle after
  assign rdata_nxt = ~bus_i.rd ? `DIC_ZERO_BYTE :
                     hit_enable ? enable_r :
                     hit_flags ? flags : // [RULE8]
                     hit_mask ? mask_r :
                     hit_pending ? pending :
                     hit_ctrl ? ctrl_view :
                     hit_overrun ? overrun :
                     `DIC_ZERO_BYTE;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enable_r <= `DIC_RST_BYTE; // [RULE1]
      mask_r <= `DIC_RST_BYTE;
      ctrl_r <= `DIC_RST_CTRL;
      ext_pin_r <= 1'b0;
    end else begin
      enable_r <= enable_nxt;
      mask_r <= mask_nxt;
      ctrl_r <= ctrl_nxt;
      ext_pin_r <= ext_pin_i;
    end
  end

  // outputs come from flops, so the request trails its cause by one cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= `DIC_RST_BYTE;
      irq_r <= 1'b0;
      pending_r <= `DIC_RST_BYTE;
    end else begin
      rdata_r <= rd_mapped ? rdata_nxt : `DIC_ZERO_BYTE;
      irq_r <= |pending; // [RULE17] [RULE16]
      pending_r <= pending;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o = irq_r;
  assign pending_o = pending_r;

endmodule

//--- verif/dic_host.sv
// host processor model on the register port
`timescale 1ns/1ps
module dic_host (
  // clock
  input wire logic clk_i,
  // register port
  output dic_pkg::dic_bus_req_t bus_o,
  input wire logic [7:0] rdata_i,
  // request from the device
  input wire logic irq_i
);
  initial bus_o = '0;
  // idle lines show the inverse so a stale address never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_o <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1 d = rdata_i;
  endtask
  // service only when asked, as a polled host would not
  task automatic service(output logic [7:0] f);
    f = 8'h00;
    if (irq_i === 1'b1) begin
      rd(8'h0c, f);
      wr(8'h0c, f);
    end
  endtask
endmodule

//--- verif/dic_top_chk.sv
// port checker for the display interrupt control
`timescale 1ns/1ps
module dic_top_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // watched ports
  input wire dic_pkg::dic_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire dic_pkg::dic_src_t src_i,
  input wire logic ext_pin_i,
  input wire logic irq_o,
  input wire logic [7:0] pending_o
);
  logic [7:0] en_r, mk_r, ev1_r, ev2_r;
  wire logic [7:0] en_nxt = (bus_i.wr && bus_i.addr == 8'h0b) ? bus_i.wdata : en_r;
  wire logic [7:0] mk_nxt = (bus_i.wr && bus_i.addr == 8'h0d) ? bus_i.wdata : mk_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      en_r <= 8'h00;
      mk_r <= 8'h00;
      ev1_r <= 8'h00;
      ev2_r <= 8'h00;
    end else begin
      en_r <= en_nxt;
      mk_r <= mk_nxt;
      ev1_r <= src_i & en_nxt & ~mk_nxt;
      ev2_r <= ev1_r;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  rst_out_a: assert property ($fell(reset_i) |-> !irq_o && pending_o == 8'h00)
    else $error("outputs set after reset");
  rd_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  en_read_a: assert property (
    $past(bus_i.rd && bus_i.addr == 8'h0b) |-> rdata_o == $past(en_r))
    else $error("enable read back wrong");
  unmap_read_a: assert property (
    $past(bus_i.rd && bus_i.addr > 8'h43) |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  irq_lvl_a: assert property (irq_o == (pending_o != 8'h00))
    else $error("request disagrees with pending");
  gate_pend_a: assert property (
    (pending_o & ~($past(en_r) & ~$past(mk_r))) == 8'h00)
    else $error("disabled or masked source pending");
  ev_pend_a: assert property ((pending_o & ev2_r) == ev2_r)
    else $error("event did not raise pending");
  // pin edges also feed bit 6, so it is left out here
  w1c_clear_a: assert property (
    bus_i.wr && bus_i.addr == 8'h0c && (src_i & bus_i.wdata & 8'hbf) == 8'h00
    ##1 !bus_i.wr && (src_i & $past(bus_i.wdata) & 8'hbf) == 8'h00
    |-> ##1 (pending_o & $past(bus_i.wdata, 2) & 8'hbf) == 8'h00)
    else $error("write one did not clear");
  // pending_o lags the flags by one flop, so a write shows two edges later
  flag_hold_a: assert property (
    !bus_i.wr |-> ##2 (pending_o & $past(pending_o)) == $past(pending_o))
    else $error("pending dropped without clear");
  cover property (irq_o);
  cover property (bus_i.wr && bus_i.addr == 8'h0c && pending_o != 8'h00);
  cover property ($rose(ext_pin_i));
endmodule

bind dic_top dic_top_chk chk_u (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .src_i(src_i), .ext_pin_i(ext_pin_i), .irq_o(irq_o),
  .pending_o(pending_o));

//--- verif/testbench.sv
// self-checking bench for the display interrupt control
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  dic_pkg::dic_src_t src_i = '0;
  logic ext_pin_i = 1'b0;
  dic_pkg::dic_bus_req_t bus;
  logic [7:0] rdata, pend, got;
  logic irq;
  int errors = 0;
  int n_checks = 0;
  int m_en, m_mk, m_fl, v;
  always #5 clk_i = ~clk_i;
  dic_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata),
    .src_i(src_i), .ext_pin_i(ext_pin_i), .irq_o(irq), .pending_o(pend));
  dic_host host_u (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata), .irq_i(irq));
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, got);
    chk(e, got);
  endtask
  // the request trails an event or clear by two edges
  task automatic irqchk();
    repeat (3) @(posedge clk_i);
    #1 chk(8'(m_fl & m_en & ~m_mk), pend);
    chk({7'h00, (m_fl & m_en & ~m_mk) != 0}, {7'h00, irq});
  endtask
  task automatic regw(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(a, d);
    if (a == 8'h0b) m_en = d;
    if (a == 8'h0d) m_mk = d;
    if (a == 8'h0c) m_fl &= ~d;
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge clk_i);
    src_i <= e;
    @(posedge clk_i);
    src_i <= '0;
    m_fl |= e;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hc029_a42e));
    m_en = 0;
    m_mk = 0;
    m_fl = 0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    rdchk(8'h0b, 8'h00);
    rdchk(8'h0c, 8'h00);
    rdchk(8'h0d, 8'h00);
    rdchk(8'h80, 8'h00);
    $display("test reset done");
    // first pass fully open, second pass random enable and mask
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      regw(8'h0b, 8'(i < 8 ? 255 : v));
      regw(8'h0d, 8'(i < 8 ? 0 : v >> 8));
      rdchk(8'h0b, 8'(m_en));
      pulse(8'(1 << (i % 8)));
      rdchk(8'h0c, 8'(m_fl));
      irqchk();
      regw(8'h0c, ~8'(m_fl));
      rdchk(8'h0c, 8'(m_fl));
      regw(8'h0c, 8'(m_fl));
      rdchk(8'h0c, 8'(m_fl));
      irqchk();
    end
    $display("test single sources done");
    for (int i = 0; i < 20; i++) begin
      pulse(8'($urandom));
      regw(8'h0c, 8'($urandom));
      rdchk(8'h0c, 8'(m_fl));
      irqchk();
    end
    $display("test random events done");
    // the second single-source pass may have left mask bit 6 set, which would hide the pin request
    regw(8'h0d, 8'h00);
    regw(8'h0b, 8'h40);
    regw(8'h0c, 8'hff);
    @(posedge clk_i);
    ext_pin_i <= 1'b1;
    m_fl |= 8'h40;
    repeat (3) @(posedge clk_i);
    rdchk(8'h0c, 8'(m_fl));
    irqchk();
    host_u.service(got);
    m_fl = 0;
    chk(8'h40, got);
    ext_pin_i <= 1'b0;
    irqchk();
    $display("test pin edge done");
    // a second reset in mid-run must bring every register back to zero
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    m_en = 0;
    m_mk = 0;
    m_fl = 0;
    rdchk(8'h0b, 8'h00);
    rdchk(8'h0c, 8'h00);
    irqchk();
    $display("test mid-run reset done");
    // falling pin edge, software set, overrun and pending view
    regw(8'h0b, 8'hff);
    regw(8'h41, 8'h03);
    rdchk(8'h41, 8'h03);
    @(posedge clk_i);
    ext_pin_i <= 1'b1;
    @(posedge clk_i);
    ext_pin_i <= 1'b0;
    m_fl |= 8'h40;
    regw(8'h42, 8'h05);
    m_fl |= 8'h05;
    pulse(8'h04);
    rdchk(8'h0c, 8'(m_fl));
    rdchk(8'h43, 8'h04);
    rdchk(8'h43, 8'h00);
    rdchk(8'h40, 8'(m_fl & m_en & ~m_mk));
    irqchk();
    // software set is refused once its enable is off, and the pending view is read-only
    regw(8'h41, 8'h00);
    regw(8'h42, 8'h02);
    regw(8'h40, 8'h00);
    rdchk(8'h0c, 8'(m_fl));
    rdchk(8'h40, 8'(m_fl & m_en & ~m_mk));
    $display("test control and overrun done");
    wrap_up();
  end
endmodule
